// ===== hdl/panel_power_control_commands.v
`timescale 1ns/1ps
`include "panel_power_defs.vh"

// Notes on behaviour
// RQ1: lut bit five picks register table
// RQ2: bits seven-six pick display resolution
// RQ3: shutdown clear stops converter, keeps registers
// RQ4: reset bit clear restores all defaults
// RQ5: bit zero selects internal gate supply
// RQ6: bit one selects internal source supply
// RQ7: two bits select gate rail level
// RQ8: bit two picks common level source
// RQ9: six-bit positive source level, default 100110
// RQ10: six-bit negative source level, default 100110
// RQ11: red level six bits plus polarity
// RQ12: power off runs sequence, busy low
// RQ13: power off disables drivers, keeps registers
// RQ14: three two-bit rail off delays
// RQ15: power on runs sequence, busy low
// RQ16: host measures off-state only after command
// RQ17: booster phase A timing, strength, period
// RQ18: booster phase B same encodings
// RQ19: booster phase C off time, strength
// RQ20: extra parameters ignored, fields apply immediately

module panel_power_control_commands #(
    parameter MS_CYCLES = `MS_CYCLES
) (
    input  wire       clk,
    input  wire       sys_rst,
    input  wire       csb_n,
    input  wire       scl,
    input  wire       sda,
    input  wire       dc,
    output wire       busy_n,
    output wire       charge_pump_en,
    output wire       rail_pos_en,
    output wire       rail_neg_en,
    output wire       rail_red_en,
    output wire       drivers_en,
    output wire       measure_en,
    output wire       outputs_float,
    output wire       lut_from_register,
    output wire [1:0] resolution_select,
    output wire       gate_supply_internal,
    output wire       source_supply_internal,
    output wire [1:0] gate_rail_level,
    output wire       common_level_source,
    output wire [5:0] source_high_level,
    output wire [5:0] source_low_level,
    output wire [5:0] red_level,
    output wire       red_negative,
    output wire [7:0] booster_phase_a,
    output wire [7:0] booster_phase_b,
    output wire [7:0] booster_phase_c
);

    localparam PRE_W = $clog2(MS_CYCLES + 1);
    // the prescaler wraps after MS_CYCLES clocks, one millisecond
    localparam [31:0]      PRE_LAST_W = MS_CYCLES - 1;
    localparam [PRE_W-1:0] PRE_LAST   = PRE_LAST_W[PRE_W-1:0];
    localparam [PRE_W-1:0] PRE_ONE    = {{(PRE_W-1){1'b0}}, 1'b1};

    localparam [6:0] ST_OFF  = 7'h01;
    localparam [6:0] ST_UP_A = 7'h02;
    localparam [6:0] ST_UP_B = 7'h04;
    localparam [6:0] ST_ON   = 7'h08;
    localparam [6:0] ST_DN_P = 7'h10;
    localparam [6:0] ST_DN_N = 7'h20;
    localparam [6:0] ST_DN_R = 7'h40;

    wire       byte_valid;
    wire       byte_dc;
    wire [7:0] byte_data;

    reg [7:0]       panel_configuration_ff;
    reg [7:0]       power_source_select_ff;
    reg [7:0]       power_gate_level_ff;
    reg [7:0]       power_source_high_level_ff;
    reg [7:0]       power_source_low_level_ff;
    reg [7:0]       power_red_level_ff;
    reg [7:0]       poweroff_step_delays_ff;
    reg [7:0]       booster_phase_a_ff;
    reg [7:0]       booster_phase_b_ff;
    reg [7:0]       booster_phase_c_ff;
    reg [7:0]       cmd_ff;
    reg [2:0]       idx_ff;
    reg [6:0]       state_ff;
    reg [6:0]       nxt_state;
    reg             busy_n_ff;
    reg             measure_ff;
    reg [PRE_W-1:0] pre_ff;
    reg [6:0]       elapsed_ff;
    reg [6:0]       target_ms;
    reg [2:0]       nparam;

    // ****************************************
    // serial port
    // ****************************************
    serial_byte_receiver u_rx (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .csb_n      (csb_n),
        .scl        (scl),
        .sda        (sda),
        .dc         (dc),
        .byte_valid (byte_valid),
        .byte_dc    (byte_dc),
        .byte_data  (byte_data)
    );

    function [6:0] off_ms;
        input [1:0] code;
        begin
            case (code)
                2'h0:    off_ms = `OFF_MS_0;
                2'h1:    off_ms = `OFF_MS_1;
                2'h2:    off_ms = `OFF_MS_2;
                default: off_ms = `OFF_MS_3;
            endcase
        end
    endfunction

    function [6:0] ss_ms;
        input [1:0] code;
        begin
            case (code)
                2'h0:    ss_ms = `SS_MS_0;
                2'h1:    ss_ms = `SS_MS_1;
                2'h2:    ss_ms = `SS_MS_2;
                default: ss_ms = `SS_MS_3;
            endcase
        end
    endfunction

    // ****************************************
    // command decode
    // ****************************************
    wire cmd_byte   = byte_valid & ~byte_dc;
    wire param_byte = byte_valid & byte_dc & (idx_ff < nparam); // see RQ20
    wire shutdown_n = panel_configuration_ff[`PANEL_SHD_BIT];
    wire soft_rst   = param_byte & (cmd_ff == `CMD_PANEL)
                      & ~byte_data[`PANEL_RST_BIT]; // see RQ4
    // power commands during a sequence are dropped; the host waits on busy
    wire pon_go     = cmd_byte & (byte_data == `CMD_POWER_ON)
                      & (state_ff == ST_OFF) & shutdown_n; // see RQ15
    wire pof_go     = cmd_byte & (byte_data == `CMD_POWER_OFF)
                      & (state_ff == ST_ON); // see RQ12
    wire power_measure_cmd_go    = cmd_byte & (byte_data == `CMD_MEASURE); // see RQ16

    always @* begin
        case (cmd_ff)
            `CMD_PANEL:      nparam = `NPARAM_PANEL;
            `CMD_POWER:      nparam = `NPARAM_POWER;
            `CMD_OFF_DELAYS: nparam = `NPARAM_DELAYS;
            `CMD_BOOSTER:    nparam = `NPARAM_BOOSTER;
            default:         nparam = 3'h0;
        endcase
    end

    // ****************************************
    // parameter registers
    // ****************************************
    always @(posedge clk) begin
        if (sys_rst | soft_rst) begin // see RQ4
            panel_configuration_ff     <= `RST_PANEL;
            power_source_select_ff     <= `RST_PWR_SRC;
            power_gate_level_ff        <= `RST_PWR_GATE;
            power_source_high_level_ff <= `RST_PWR_HIGH;
            power_source_low_level_ff  <= `RST_PWR_LOW;
            power_red_level_ff         <= `RST_PWR_RED;
            poweroff_step_delays_ff    <= `RST_OFF_DELAYS;
            booster_phase_a_ff         <= `RST_BOOST_A;
            booster_phase_b_ff         <= `RST_BOOST_B;
            booster_phase_c_ff         <= `RST_BOOST_C;
            // clearing the command drops any bytes trailing a soft reset
            cmd_ff                     <= `CMD_NONE;
            idx_ff                     <= 3'h0;
        end else if (cmd_byte) begin
            cmd_ff <= byte_data;
            idx_ff <= 3'h0;
        end else if (param_byte) begin
            // each byte lands in its field on arrival
            idx_ff <= idx_ff + 3'h1; // see RQ20
            case (cmd_ff)
                `CMD_PANEL:
                    panel_configuration_ff <= byte_data; // see RQ1 RQ2 RQ3
                `CMD_POWER:
                    case (idx_ff)
                        3'h0:    power_source_select_ff     <= byte_data; // see RQ5 RQ6
                        3'h1:    power_gate_level_ff        <= byte_data; // see RQ7 RQ8
                        3'h2:    power_source_high_level_ff <= byte_data; // see RQ9
                        3'h3:    power_source_low_level_ff  <= byte_data; // see RQ10
                        default: power_red_level_ff         <= byte_data; // see RQ11
                    endcase
                `CMD_OFF_DELAYS:
                    poweroff_step_delays_ff <= byte_data; // see RQ14
                default:
                    case (idx_ff)
                        3'h0:    booster_phase_a_ff <= byte_data; // see RQ17
                        3'h1:    booster_phase_b_ff <= byte_data; // see RQ18
                        default: booster_phase_c_ff <= byte_data; // see RQ19
                    endcase
            endcase
        end
    end

    // ****************************************
    // millisecond timer, restarted on every state change
    // ****************************************
    wire ms_tick   = (pre_ff == PRE_LAST);
    wire step_done = ms_tick & ((elapsed_ff + 7'h01) == target_ms);

    always @* begin
        case (state_ff)
            ST_UP_A: target_ms = ss_ms(booster_phase_a_ff[`BOOST_PER_LSB +: 2]); // see RQ17
            ST_UP_B: target_ms = ss_ms(booster_phase_b_ff[`BOOST_PER_LSB +: 2]); // see RQ18
            ST_DN_P: target_ms = off_ms(poweroff_step_delays_ff[`DLY_POS_LSB +: 2]); // see RQ14
            ST_DN_N: target_ms = off_ms(poweroff_step_delays_ff[`DLY_NEG_LSB +: 2]); // see RQ14
            ST_DN_R: target_ms = off_ms(poweroff_step_delays_ff[`DLY_RED_LSB +: 2]); // see RQ14
            default: target_ms = 7'h00;
        endcase
    end

    // ****************************************
    // power sequencer
    // ****************************************
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_OFF:  if (pon_go) nxt_state = ST_UP_A; // see RQ15
            ST_UP_A: if (step_done) nxt_state = ST_UP_B;
            ST_UP_B: if (step_done) nxt_state = ST_ON;
            ST_ON:   if (pof_go) nxt_state = ST_DN_P; // see RQ12
            ST_DN_P: if (step_done) nxt_state = ST_DN_N;
            ST_DN_N: if (step_done) nxt_state = ST_DN_R;
            ST_DN_R: if (step_done) nxt_state = ST_OFF;
            default: nxt_state = ST_OFF;
        endcase
        // shutdown drops the converter at once, no sequence
        if (~shutdown_n | soft_rst) begin
            nxt_state = ST_OFF; // see RQ3 RQ4
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            state_ff   <= ST_OFF;
            busy_n_ff  <= 1'b1;
            measure_ff <= 1'b0;
            pre_ff     <= {PRE_W{1'b0}};
            elapsed_ff <= 7'h00;
        end else begin
            state_ff  <= nxt_state;
            // busy follows the next state, so it moves on the edge the command lands
            busy_n_ff <= (nxt_state == ST_OFF) | (nxt_state == ST_ON); // see RQ12 RQ15
            if (pof_go | soft_rst | ~shutdown_n) begin
                measure_ff <= 1'b0; // see RQ13
            end else if (power_measure_cmd_go) begin
                measure_ff <= 1'b1; // see RQ16
            end
            if (nxt_state != state_ff) begin
                pre_ff     <= {PRE_W{1'b0}};
                elapsed_ff <= 7'h00;
            end else begin
                pre_ff <= ms_tick ? {PRE_W{1'b0}} : pre_ff + PRE_ONE;
                if (ms_tick) begin
                    elapsed_ff <= elapsed_ff + 7'h01;
                end
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // on power off, rails drop positive first, then negative, then red
    assign busy_n            = busy_n_ff;
    assign charge_pump_en    = ~state_ff[0]; // see RQ3 RQ13
    assign rail_pos_en       = |state_ff[3:1];
    assign rail_neg_en       = |state_ff[4:1];
    assign rail_red_en       = |state_ff[5:1];
    assign drivers_en        = state_ff[3]; // see RQ13
    assign measure_en        = measure_ff | state_ff[3]; // see RQ16
    assign outputs_float     = ~state_ff[3]; // see RQ3 RQ4

    assign lut_from_register      = panel_configuration_ff[`PANEL_LUT_BIT]; // see RQ1
    assign resolution_select      = panel_configuration_ff[`PANEL_RES_LSB +: 2]; // see RQ2
    assign gate_supply_internal   = power_source_select_ff[`PWR_GATE_BIT]; // see RQ5
    assign source_supply_internal = power_source_select_ff[`PWR_SRC_BIT]; // see RQ6
    assign gate_rail_level        = power_gate_level_ff[`PWR_LV_LSB +: 2]; // see RQ7
    assign common_level_source    = power_gate_level_ff[`PWR_COM_BIT]; // see RQ8
    assign source_high_level      = power_source_high_level_ff[`PWR_LEVEL_MSB:0]; // see RQ9
    assign source_low_level       = power_source_low_level_ff[`PWR_LEVEL_MSB:0]; // see RQ10
    assign red_level              = power_red_level_ff[`PWR_LEVEL_MSB:0]; // see RQ11
    assign red_negative           = power_red_level_ff[`PWR_RED_POL_BIT]; // see RQ11
    assign booster_phase_a        = booster_phase_a_ff;
    assign booster_phase_b        = booster_phase_b_ff;
    assign booster_phase_c        = booster_phase_c_ff; // see RQ19

endmodule // panel_power_control_commands

// ===== hdl/panel_power_defs.vh
`ifndef PANEL_POWER_DEFS_VH
`define PANEL_POWER_DEFS_VH

// ****************************************
// clock and timing
// ****************************************
`define CLK_PERIOD_NS    10
`define MS_NS            1000000
`define MS_CYCLES        (`MS_NS / `CLK_PERIOD_NS)

// ****************************************
// command codes
// ****************************************
`define CMD_PANEL        8'h00
`define CMD_POWER        8'h01
`define CMD_POWER_OFF    8'h02
`define CMD_OFF_DELAYS   8'h03
`define CMD_POWER_ON     8'h04
`define CMD_MEASURE      8'h05
`define CMD_BOOSTER      8'h06
`define CMD_NONE         8'hFF

// ****************************************
// parameter byte counts
// ****************************************
`define NPARAM_PANEL     3'h1
`define NPARAM_POWER     3'h5
`define NPARAM_DELAYS    3'h1
`define NPARAM_BOOSTER   3'h3

// ****************************************
// reset values
// ****************************************
`define RST_PANEL        8'h07
`define RST_PWR_SRC      8'h03
`define RST_PWR_GATE     8'h00
`define RST_PWR_HIGH     8'h26
`define RST_PWR_LOW      8'h26
`define RST_PWR_RED      8'h03
`define RST_OFF_DELAYS   8'h00
`define RST_BOOST_A      8'h03
`define RST_BOOST_B      8'h00
`define RST_BOOST_C      8'h26

// ****************************************
// field positions
// ****************************************
`define PANEL_RST_BIT    0
`define PANEL_SHD_BIT    1
`define PANEL_LUT_BIT    5
`define PANEL_RES_LSB    6
`define PWR_GATE_BIT     0
`define PWR_SRC_BIT      1
`define PWR_LV_LSB       0
`define PWR_COM_BIT      2
`define PWR_LEVEL_MSB    5
`define PWR_RED_POL_BIT  6
`define DLY_RED_LSB      0
`define DLY_NEG_LSB      2
`define DLY_POS_LSB      4
`define BOOST_PER_LSB    6

// ****************************************
// delays in milliseconds
// ****************************************
`define OFF_MS_0         7'h05
`define OFF_MS_1         7'h0A
`define OFF_MS_2         7'h14
`define OFF_MS_3         7'h28
`define SS_MS_0          7'h0A
`define SS_MS_1          7'h14
`define SS_MS_2          7'h1E
`define SS_MS_3          7'h64

`endif

// ===== hdl/serial_byte_receiver.v
`timescale 1ns/1ps
`include "panel_power_defs.vh"

module serial_byte_receiver (
    input  wire       clk,
    input  wire       sys_rst,
    input  wire       csb_n,
    input  wire       scl,
    input  wire       sda,
    input  wire       dc,
    output wire       byte_valid,
    output wire       byte_dc,
    output wire [7:0] byte_data
);

    reg       scl_d_ff;
    reg [6:0] shift_ff;
    reg [2:0] cnt_ff;
    reg       valid_ff;
    reg       dc_ff;
    reg [7:0] data_ff;

    wire rise = scl & ~scl_d_ff & ~csb_n;

    // ****************************************
    // shift msb first, one byte per eight rising edges
    // ****************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            scl_d_ff <= 1'b0;
            shift_ff <= 7'h00;
            cnt_ff   <= 3'h0;
            valid_ff <= 1'b0;
            dc_ff    <= 1'b0;
            data_ff  <= 8'h00;
        end else begin
            scl_d_ff <= scl;
            valid_ff <= 1'b0;
            if (csb_n) begin
                // a partial byte is dropped when select rises
                cnt_ff <= 3'h0;
            end else if (rise) begin
                shift_ff <= {shift_ff[5:0], sda};
                cnt_ff   <= cnt_ff + 3'h1;
                if (cnt_ff == 3'h7) begin
                    valid_ff <= 1'b1;
                    dc_ff    <= dc;
                    data_ff  <= {shift_ff, sda};
                end
            end
        end
    end

    assign byte_valid = valid_ff;
    assign byte_dc    = dc_ff;
    assign byte_data  = data_ff;

endmodule // serial_byte_receiver

// ===== tb/panel_power_props.sv
`timescale 1ns/1ps

// ****************************************
// power sequencing checker
// ****************************************
module panel_power_props #(
    parameter MS_CYCLES = 10
) (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       csb_n,
    input wire logic       busy_n,
    input wire logic       charge_pump_en,
    input wire logic       rail_pos_en,
    input wire logic       rail_neg_en,
    input wire logic       rail_red_en,
    input wire logic       drivers_en,
    input wire logic       measure_en,
    input wire logic       outputs_float,
    input wire logic [1:0] gate_rail_level,
    input wire logic [5:0] source_high_level,
    input wire logic [5:0] red_level,
    input wire logic [7:0] booster_phase_c
);
    // longest legal busy span: two 100 ms soft-start phases
    localparam int MAX_BUSY = 200 * MS_CYCLES + 4;
    logic [31:0] busy_cnt_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    always @(posedge clk) begin
        if (sys_rst || busy_n)
            busy_cnt_ff <= 32'h0;
        else
            busy_cnt_ff <= busy_cnt_ff + 32'h1;
    end

    drivers_full_power_a: assert property (drivers_en |-> charge_pump_en && rail_pos_en && rail_neg_en && rail_red_en && measure_en)
        else $error("drivers on without every rail");
    float_follows_drv_a: assert property (outputs_float == !drivers_en)
        else $error("float flag disagrees with drivers");
    rail_off_order_a: assert property ((rail_pos_en |-> rail_neg_en) and (rail_neg_en |-> rail_red_en))
        else $error("rails released out of order");
    rails_need_pump_a: assert property (rail_red_en |-> charge_pump_en)
        else $error("rail on with pump off");
    busy_start_pump_a: assert property ($fell(busy_n) |-> charge_pump_en && !drivers_en)
        else $error("busy fell outside a sequence");
    ready_on_power_a: assert property ($rose(drivers_en) |-> ##[0:1] busy_n)
        else $error("busy not released at power on");
    busy_bounded_a: assert property (busy_cnt_ff <= MAX_BUSY)
        else $error("busy held too long");
    busy_off_state_a: assert property (!busy_n |-> charge_pump_en)
        else $error("busy low while off");
    reset_defaults_a: assert property (disable iff (1'b0) sys_rst |=> busy_n && !charge_pump_en && !measure_en && gate_rail_level == 2'h0 && source_high_level == 6'h26 && red_level == 6'h03 && booster_phase_c == 8'h26)
        else $error("reset values wrong");
    config_quiet_a: assert property (csb_n [*3] |=> $stable(gate_rail_level) && $stable(source_high_level) && $stable(booster_phase_c))
        else $error("config moved without a byte");
endmodule // panel_power_props

bind panel_power_control_commands panel_power_props #(.MS_CYCLES(MS_CYCLES)) i_props (
    .clk, .sys_rst, .csb_n, .busy_n, .charge_pump_en, .rail_pos_en, .rail_neg_en,
    .rail_red_en, .drivers_en, .measure_en, .outputs_float, .gate_rail_level,
    .source_high_level, .red_level, .booster_phase_c
);

// ===== tb/serial_host_model.sv
`timescale 1ns/1ps

// ****************************************
// host side of the write-only serial port
// ****************************************
module serial_host_model (
    input  wire logic clk,
    output logic      csb_n,
    output logic      scl,
    output logic      sda,
    output logic      dc
);
    initial begin
        csb_n = 1'b1;
        scl   = 1'b0;
        sda   = 1'b0;
        dc    = 1'b1;
    end

    // two clk per scl level so the sampler sees both; scl stands low between bytes
    task automatic send_byte(input logic is_param, input logic [7:0] b);
        integer i;
        @(negedge clk);
        csb_n = 1'b0;
        dc    = is_param;
        for (i = 7; i >= 0; i--) begin
            sda = b[i];
            repeat (2) @(negedge clk);
            scl = 1'b1;
            repeat (2) @(negedge clk);
            scl = 1'b0;
        end
        repeat (2) @(negedge clk);
        csb_n = 1'b1;
        // a deselected line carries no trace of the last bit
        sda   = ~sda;
    endtask
endmodule // serial_host_model

// ===== tb/panel_power_control_commands_tb.sv
`timescale 1ns/1ps

module panel_power_control_commands_tb;
    logic        clk;
    logic        sys_rst;
    wire         csb_n, scl, sda, dc;
    wire         busy_n, charge_pump_en, rail_pos_en, rail_neg_en, rail_red_en;
    wire         drivers_en, measure_en, outputs_float, lut_from_register;
    wire         gate_supply_internal, source_supply_internal, common_level_source;
    wire         red_negative;
    wire [1:0]   resolution_select, gate_rail_level;
    wire [5:0]   source_high_level, source_low_level, red_level;
    wire [7:0]   booster_phase_a, booster_phase_b, booster_phase_c;
    wire [50:0]  dut_vec;
    logic [7:0]  exp_reg [0:8];
    integer      mismatches;
    integer      check_count;
    integer      r;
    integer      c;
    // rows: command, parameter count, up to five parameter bytes
    logic [55:0] rows [0:8] = '{56'h01_05_00012B0045, 56'h01_05_0306002B03,
        56'h01_02_0103000000, 56'h06_03_C73F260000, 56'h06_04_1285112200,
        56'h00_01_6300000000, 56'h00_02_A300000000, 56'h20_02_0100000000,
        56'h00_01_C300000000};

    assign dut_vec = {lut_from_register, resolution_select, gate_supply_internal,
        source_supply_internal, gate_rail_level, common_level_source, source_high_level,
        source_low_level, red_negative, red_level, booster_phase_a, booster_phase_b,
        booster_phase_c};

    serial_host_model i_host (.clk, .csb_n, .scl, .sda, .dc);

    panel_power_control_commands #(.MS_CYCLES(10)) i_dut (
        .clk, .sys_rst, .csb_n, .scl, .sda, .dc, .busy_n, .charge_pump_en, .rail_pos_en,
        .rail_neg_en, .rail_red_en, .drivers_en, .measure_en, .outputs_float,
        .lut_from_register, .resolution_select, .gate_supply_internal,
        .source_supply_internal, .gate_rail_level, .common_level_source,
        .source_high_level, .source_low_level, .red_level, .red_negative,
        .booster_phase_a, .booster_phase_b, .booster_phase_c
    );

    // ****************************************
    // expected register model
    // ****************************************
    task automatic set_defaults();
        exp_reg = '{8'h07, 8'h03, 8'h00, 8'h26, 8'h26, 8'h03, 8'h03, 8'h00, 8'h26};
    endtask

    task automatic model_byte(input logic [7:0] cmd, input integer idx, input logic [7:0] d);
        if (cmd == 8'h00 && idx == 0) begin
            exp_reg[0] = d;
            if (!d[0])
                set_defaults();
        end else if (cmd == 8'h01 && idx < 5)
            exp_reg[1 + idx] = d;
        else if (cmd == 8'h06 && idx < 3)
            exp_reg[6 + idx] = d;
    endtask

    function automatic logic [50:0] exp_vec();
        return {exp_reg[0][5], exp_reg[0][7:6], exp_reg[1][0], exp_reg[1][1],
            exp_reg[2][1:0], exp_reg[2][2], exp_reg[3][5:0], exp_reg[4][5:0],
            exp_reg[5][6:0], exp_reg[6], exp_reg[7], exp_reg[8]};
    endfunction

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string what, input logic [50:0] exp, input logic [50:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmd_seq(input logic [7:0] cmd, input integer n, input logic [39:0] p);
        integer i;
        i_host.send_byte(1'b0, cmd);
        for (i = 0; i < n; i++) begin
            i_host.send_byte(1'b1, p[39 - 8 * i -: 8]);
            model_byte(cmd, i, p[39 - 8 * i -: 8]);
        end
    endtask

    // busy has already fallen when the command byte ends, so a few cycles go uncounted
    task automatic time_busy(output integer cycles);
        cycles = 0;
        while (busy_n === 1'b0 && cycles < 5000) begin
            @(negedge clk);
            cycles++;
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #200000;
        mismatches++;
        final_report();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        mismatches  = 0;
        check_count = 0;
        sys_rst     = 1'b1;
        set_defaults();
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        check("reset config", exp_vec(), dut_vec);
        for (r = 0; r < 9; r++) begin
            cmd_seq(rows[r][55:48], rows[r][47:40], rows[r][39:0]);
            check("config", exp_vec(), dut_vec);
        end
        $display("test table done");
        cmd_seq(8'h06, 2, 40'h4305000000);
        cmd_seq(8'h04, 0, 40'h0);
        check("on start", 51'h6, 51'({charge_pump_en, rail_pos_en, drivers_en}));
        time_busy(c);
        check("on time", 51'h1, 51'(c >= 295 && c <= 301));
        check("on state", 51'h3, 51'({drivers_en, measure_en}));
        cmd_seq(8'h04, 0, 40'h0);
        check("on again", 51'h1, 51'(busy_n));
        cmd_seq(8'h03, 1, 40'h1B00000000);
        cmd_seq(8'h02, 0, 40'h0);
        check("off first step", 51'h3, 51'({rail_pos_en, rail_neg_en, rail_red_en}));
        time_busy(c);
        check("off time", 51'h1, 51'(c >= 695 && c <= 701));
        check("off state", 51'h1, 51'({charge_pump_en, measure_en, outputs_float}));
        check("off kept", exp_vec(), dut_vec);
        $display("test power cycle done");
        cmd_seq(8'h05, 0, 40'h0);
        check("measure", 51'h1, 51'(measure_en));
        cmd_seq(8'h04, 0, 40'h0);
        repeat (20) @(negedge clk);
        cmd_seq(8'h00, 1, 40'hC100000000);
        check("shutdown", 51'h2, 51'({busy_n, charge_pump_en}));
        check("shutdown kept", exp_vec(), dut_vec);
        cmd_seq(8'h00, 1, 40'h4200000000);
        check("soft reset", exp_vec(), dut_vec);
        check("soft reset off", 51'h1, 51'({measure_en, drivers_en, busy_n}));
        $display("test shutdown and soft reset done");
        cmd_seq(8'h06, 2, 40'hC785000000);
        cmd_seq(8'h04, 0, 40'h0);
        time_busy(c);
        check("slow on time", 51'h1, 51'(c >= 1295 && c <= 1301));
        cmd_seq(8'h02, 0, 40'h0);
        time_busy(c);
        check("short off time", 51'h1, 51'(c >= 145 && c <= 151));
        check("short off kept", exp_vec(), dut_vec);
        $display("test slow power cycle done");
        cmd_seq(8'h01, 2, 40'h0307000000);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        set_defaults();
        check("hard reset", exp_vec(), dut_vec);
        $display("test hard reset done");
        final_report();
    end
endmodule // panel_power_control_commands_tb
